// ==== rtl/scm_params.svh ====
// register map, field positions, reset values and wake-up counts of the clock mode block
`ifndef SCM_PARAMS_SVH
`define SCM_PARAMS_SVH

`define SCM_ADDR_W          8
`define SCM_ADDR_MODE       8'h00
`define SCM_ADDR_CTRL       8'h01
`define SCM_ADDR_STAT       8'h02
`define SCM_ADDR_CLR        8'h03
`define SCM_ADDR_IEN        8'h04

`define SCM_MODE_RESET      8'h03
`define SCM_MODE_WR_MASK    8'hF3
`define SCM_BIT_HCLK_SEL    0
`define SCM_BIT_IDLE_EN     1
`define SCM_BIT_HS_RDY      2
`define SCM_BIT_LS_RDY      3
`define SCM_BIT_FAST_EN     4
`define SCM_DIV_LSB         5
`define SCM_DIV_MSB         7

`define SCM_CTRL_RESET      8'h00
`define SCM_BIT_CLK_KEEP    0
`define SCM_BIT_LVD_EN      1

`define SCM_EVT_W           4
`define SCM_EVT_HS_RDY      0
`define SCM_EVT_LS_RDY      1
`define SCM_EVT_WAKE_DONE   2
`define SCM_EVT_DEEP_REFUSE 3

`define SCM_HS_READY_CYCLES 1024
`define SCM_LS_READY_CYCLES 2

`endif

// ==== rtl/scm_pkg.sv ====
// types shared by the clock mode block
package scm_pkg;

  // one-hot power and wake states
  typedef enum logic [6:0] {
    SCM_RUN       = 7'b0000001,
    SCM_IDLE_RUN  = 7'b0000010,
    SCM_IDLE_STOP = 7'b0000100,
    SCM_SLEEP_SUB = 7'b0001000,
    SCM_SLEEP_OFF = 7'b0010000,
    SCM_WAKE_LS   = 7'b0100000,
    SCM_WAKE_WAIT = 7'b1000000
  } scm_state_e;

  // system clock routing shown to the clock tree
  typedef struct packed {
    logic       use_low;
    logic       use_full;
    logic [2:0] div_code;
  } scm_clk_sel_s;

endpackage

// ==== rtl/scm_sync.sv ====
// three-stage pin synchroniser with agreement filter and rise pulse
`timescale 1ns/1ps
module scm_sync #(
  parameter int W = 2
) (
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_level,
  output logic      [W-1:0] o_rise
);

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic s1_ff, s2_ff, s3_ff;   // capture chain
      logic lvl_ff, nxt_lvl;       // filtered level
      logic rise_ff, nxt_rise;     // one-cycle rise

      // a change is accepted only once stages two and three agree
      always_comb begin
        nxt_lvl  = lvl_ff;
        nxt_rise = 1'b0;
        if (s2_ff == s3_ff) begin
          nxt_lvl  = s3_ff;
          nxt_rise = s3_ff & ~lvl_ff;
        end
      end

      // stage one feeds only stage two
      always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
          s1_ff   <= 1'b0;
          s2_ff   <= 1'b0;
          s3_ff   <= 1'b0;
          lvl_ff  <= 1'b0;
          rise_ff <= 1'b0;
        end else begin
          s1_ff   <= i_async[g];
          s2_ff   <= s1_ff;
          s3_ff   <= s2_ff;
          lvl_ff  <= nxt_lvl;
          rise_ff <= nxt_rise;
        end
      end

      assign o_level[g] = lvl_ff;
      assign o_rise[g]  = rise_ff;
    end
  endgenerate

endmodule

// ==== rtl/scm_top.sv ====
// system clock selection, halt mode entry and oscillator wake-up sequencing
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "scm_params.svh"
module scm_top #(
  parameter int HS_READY_CYCLES = `SCM_HS_READY_CYCLES,
  parameter int LS_READY_CYCLES = `SCM_LS_READY_CYCLES
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_sys_rst,
  input  wire logic [`SCM_ADDR_W-1:0]  i_addr,
  input  wire logic [7:0]              i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  input  wire logic                    i_halt,
  input  wire logic                    i_wake,
  input  wire logic                    i_crystal_sel,
  input  wire logic                    i_wdt_en,
  input  wire logic                    i_high_speed_clock,
  input  wire logic                    i_low_speed_clock,
  output logic [7:0]                   o_rdata,
  output logic                         o_cpu_run,
  output logic                         o_sys_tick,
  output logic                         o_hs_osc_en,
  output logic                         o_ls_osc_en,
  output scm_pkg::scm_clk_sel_s        o_clk_sel,
  output scm_pkg::scm_state_e          o_power_mode,
  output logic                         o_irq
);
  import scm_pkg::*;

  // oscillator pins arrive from foreign clocks
  // only the rising edges of the pins are used, their filtered levels are left open
  logic [1:0] osc_rise;  // [0] high-speed edge, [1] low-speed edge
  logic       hs_edge;
  logic       ls_edge;

  scm_sync #(.W(2)) u_osc_sync (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   ({i_low_speed_clock, i_high_speed_clock}),
    .o_level   (),
    .o_rise    (osc_rise)
  );
  assign hs_edge = osc_rise[0];
  assign ls_edge = osc_rise[1];

  // software registers
  logic [7:0]            mode_ff, nxt_mode;   // clock mode control
  logic [7:0]            ctrl_ff, nxt_ctrl;   // keep-clock and low-volt enable
  logic [`SCM_EVT_W-1:0] stat_ff, nxt_stat;   // sticky events
  logic [`SCM_EVT_W-1:0] ien_ff, nxt_ien;     // event enables
  logic [7:0]            rdata_ff, nxt_rdata; // read data, one cycle later
  logic                  irq_ff, nxt_irq;

  // wake sequencing state
  scm_state_e  state_ff, nxt_state;
  logic [10:0] hs_cnt_ff, nxt_hs_cnt;   // high oscillator stabilisation count
  logic [1:0]  ls_cnt_ff, nxt_ls_cnt;   // low oscillator start count
  logic        hs_rdy_ff, nxt_hs_rdy;
  logic        ls_rdy_ff, nxt_ls_rdy;
  logic [`SCM_EVT_W-1:0] evt;           // one-cycle event pulses

  // clock tree outputs
  logic [5:0]   div_cnt_ff, nxt_div_cnt; // counts high-speed edges for division
  logic         tick_ff, nxt_tick;
  logic         cpu_ff, nxt_cpu;
  logic         hs_en_ff, nxt_hs_en;
  logic         ls_en_ff, nxt_ls_en;
  scm_clk_sel_s sel_ff, nxt_sel;

  // decoded control fields
  logic       hclk_sel, idle_en, fast_en, clk_keep, lvd_en, low_sel, fast_ok;
  logic [2:0] div_code;
  logic [5:0] div_mask;

  assign hclk_sel = mode_ff[`SCM_BIT_HCLK_SEL];
  assign idle_en  = mode_ff[`SCM_BIT_IDLE_EN];
  assign fast_en  = mode_ff[`SCM_BIT_FAST_EN];
  assign div_code = mode_ff[`SCM_DIV_MSB:`SCM_DIV_LSB];
  assign clk_keep = ctrl_ff[`SCM_BIT_CLK_KEEP];
  assign lvd_en   = ctrl_ff[`SCM_BIT_LVD_EN];
  // codes 000 and 001 mean the slow clock when the full clock is not chosen
  assign low_sel  = ~hclk_sel & (div_code[2:1] == 2'b00);
  // fast wake needs a crystal source, its enable bit and the slow clock not routed to the system
  assign fast_ok  = i_crystal_sel & fast_en & ~low_sel;

  // mask of divider bits: code 010 gives /64 down to 111 giving /2
  always_comb begin
    case (div_code)
      3'h2:    div_mask = 6'h3F;
      3'h3:    div_mask = 6'h1F;
      3'h4:    div_mask = 6'h0F;
      3'h5:    div_mask = 6'h07;
      3'h6:    div_mask = 6'h03;
      default: div_mask = 6'h01;
    endcase
  end

  // power state, oscillator enables and ready counters
  always_comb begin
    nxt_state  = state_ff;
    nxt_hs_cnt = hs_cnt_ff;
    nxt_ls_cnt = ls_cnt_ff;
    nxt_hs_rdy = hs_rdy_ff;
    nxt_ls_rdy = ls_rdy_ff;
    evt        = '0;
    // which oscillators run in the coming cycle
    case (state_ff)
      SCM_RUN, SCM_IDLE_RUN, SCM_WAKE_WAIT: nxt_hs_en = ~low_sel;
      SCM_WAKE_LS:                          nxt_hs_en = 1'b1;
      default:                              nxt_hs_en = 1'b0;
    endcase
    nxt_ls_en = (state_ff != SCM_SLEEP_OFF);
    // high ready: cleared while its oscillator is off, set after the count
    if (!hs_en_ff) begin
      nxt_hs_cnt = '0;
      nxt_hs_rdy = 1'b0;
    end else if (hs_edge && !hs_rdy_ff) begin
      if (hs_cnt_ff == 11'(HS_READY_CYCLES - 1)) begin
        nxt_hs_rdy = 1'b1;
        evt[`SCM_EVT_HS_RDY] = 1'b1;
      end else begin
        nxt_hs_cnt = hs_cnt_ff + 11'h001;
      end
    end
    // low ready: only the deepest sleep stops the slow oscillator
    if (!ls_en_ff) begin
      nxt_ls_cnt = '0;
      nxt_ls_rdy = 1'b0;
    end else if (ls_edge && !ls_rdy_ff) begin
      if (ls_cnt_ff == 2'(LS_READY_CYCLES - 1)) begin
        nxt_ls_rdy = 1'b1;
        evt[`SCM_EVT_LS_RDY] = 1'b1;
      end else begin
        nxt_ls_cnt = ls_cnt_ff + 2'h1;
      end
    end
    case (state_ff)
      SCM_RUN: begin
        if (i_halt) begin
          if (idle_en) begin
            nxt_state = clk_keep ? SCM_IDLE_RUN : SCM_IDLE_STOP;
          end else if (lvd_en || i_wdt_en) begin
            nxt_state = SCM_SLEEP_SUB;
            evt[`SCM_EVT_DEEP_REFUSE] = lvd_en;
          end else begin
            nxt_state = SCM_SLEEP_OFF;
          end
        end
      end
      SCM_IDLE_RUN: begin
        // oscillator never stopped, so no stabilisation wait
        if (i_wake) begin
          nxt_state = SCM_RUN;
          evt[`SCM_EVT_WAKE_DONE] = 1'b1;
        end
      end
      SCM_IDLE_STOP, SCM_SLEEP_SUB: begin
        if (i_wake) begin
          nxt_state = fast_ok ? SCM_WAKE_LS : SCM_WAKE_WAIT;
        end
      end
      SCM_SLEEP_OFF: begin
        // slow clock is dead here, so fast wake cannot help
        if (i_wake) begin
          nxt_state = SCM_WAKE_WAIT;
        end
      end
      SCM_WAKE_LS: begin
        // runs on the slow clock until the crystal is counted stable
        if (hs_rdy_ff) begin
          nxt_state = SCM_RUN;
          evt[`SCM_EVT_WAKE_DONE] = 1'b1;
        end
      end
      SCM_WAKE_WAIT: begin
        if (low_sel ? ls_rdy_ff : hs_rdy_ff) begin
          nxt_state = SCM_RUN;
          evt[`SCM_EVT_WAKE_DONE] = 1'b1;
        end
      end
      default: nxt_state = SCM_WAKE_WAIT;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_ff  <= SCM_WAKE_WAIT;  // power-on waits for the high oscillator
      hs_cnt_ff <= '0;
      ls_cnt_ff <= '0;
      hs_rdy_ff <= 1'b0;
      ls_rdy_ff <= 1'b0;
      hs_en_ff  <= 1'b1;
      ls_en_ff  <= 1'b1;
    end else begin
      state_ff  <= nxt_state;
      hs_cnt_ff <= nxt_hs_cnt;
      ls_cnt_ff <= nxt_ls_cnt;
      hs_rdy_ff <= nxt_hs_rdy;
      ls_rdy_ff <= nxt_ls_rdy;
      hs_en_ff  <= nxt_hs_en;
      ls_en_ff  <= nxt_ls_en;
    end
  end

  // system clock tick, cpu run and routing
  always_comb begin
    nxt_div_cnt = hs_edge ? div_cnt_ff + 6'h01 : div_cnt_ff;
    nxt_cpu     = (state_ff == SCM_RUN) || (state_ff == SCM_WAKE_LS && ls_rdy_ff);
    nxt_sel.use_low  = low_sel || (state_ff == SCM_WAKE_LS);
    nxt_sel.use_full = hclk_sel && (state_ff != SCM_WAKE_LS);
    nxt_sel.div_code = div_code;
    nxt_tick = 1'b0;
    // peripherals keep their clock in running idle only
    if (nxt_cpu || state_ff == SCM_IDLE_RUN) begin
      if (nxt_sel.use_low) begin
        nxt_tick = ls_edge;
      end else if (hclk_sel) begin
        nxt_tick = hs_edge;
      end else begin
        nxt_tick = hs_edge && ((div_cnt_ff & div_mask) == div_mask);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      div_cnt_ff <= '0;
      tick_ff    <= 1'b0;
      cpu_ff     <= 1'b0;
      sel_ff     <= '0;
    end else begin
      div_cnt_ff <= nxt_div_cnt;
      tick_ff    <= nxt_tick;
      cpu_ff     <= nxt_cpu;
      sel_ff     <= nxt_sel;
    end
  end

  // register writes, reads and interrupt
  always_comb begin
    nxt_mode  = mode_ff;
    nxt_ctrl  = ctrl_ff;
    nxt_ien   = ien_ff;
    nxt_rdata = 8'h00;
    nxt_stat  = stat_ff;
    // ready bits always mirror hardware
    nxt_mode[`SCM_BIT_HS_RDY] = hs_rdy_ff;
    nxt_mode[`SCM_BIT_LS_RDY] = ls_rdy_ff;
    if (i_wr) begin
      if (i_addr == `SCM_ADDR_MODE) begin
        // flag positions keep the hardware value
        nxt_mode = (i_wdata & `SCM_MODE_WR_MASK) | (nxt_mode & ~`SCM_MODE_WR_MASK);
      end else if (i_addr == `SCM_ADDR_CTRL) begin
        nxt_ctrl = {6'h00, i_wdata[1:0]};
      end else if (i_addr == `SCM_ADDR_CLR) begin
        nxt_stat = stat_ff & ~i_wdata[`SCM_EVT_W-1:0];
      end else if (i_addr == `SCM_ADDR_IEN) begin
        nxt_ien = i_wdata[`SCM_EVT_W-1:0];
      end
    end
    // a new event beats a clear in the same cycle
    nxt_stat = nxt_stat | evt;
    if (i_rd) begin
      if (i_addr == `SCM_ADDR_MODE) begin
        nxt_rdata = mode_ff;
      end else if (i_addr == `SCM_ADDR_CTRL) begin
        nxt_rdata = ctrl_ff;
      end else if (i_addr == `SCM_ADDR_STAT) begin
        nxt_rdata = {4'h0, stat_ff};
      end else if (i_addr == `SCM_ADDR_IEN) begin
        nxt_rdata = {4'h0, ien_ff};
      end else begin
        nxt_rdata = 8'h00;  // clear register and unmapped read as zero
      end
    end
    nxt_irq = |(nxt_stat & nxt_ien);
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mode_ff  <= `SCM_MODE_RESET;
      ctrl_ff  <= `SCM_CTRL_RESET;
      stat_ff  <= '0;
      ien_ff   <= '0;
      rdata_ff <= 8'h00;
      irq_ff   <= 1'b0;
    end else begin
      mode_ff  <= nxt_mode;
      ctrl_ff  <= nxt_ctrl;
      stat_ff  <= nxt_stat;
      ien_ff   <= nxt_ien;
      rdata_ff <= nxt_rdata;
      irq_ff   <= nxt_irq;
    end
  end

  assign o_rdata      = rdata_ff;
  assign o_cpu_run    = cpu_ff;
  assign o_sys_tick   = tick_ff;
  assign o_hs_osc_en  = hs_en_ff;
  assign o_ls_osc_en  = ls_en_ff;
  assign o_clk_sel    = sel_ff;
  assign o_power_mode = state_ff;
  assign o_irq        = irq_ff;

endmodule

// ==== test/scm_top_sva.sv ====
// port-level assertions for the clock mode block
`timescale 1ns/1ps
`include "scm_params.svh"
module scm_top_sva
  import scm_pkg::*;
#(
  parameter int HS_READY_CYCLES = `SCM_HS_READY_CYCLES,
  parameter int LS_READY_CYCLES = `SCM_LS_READY_CYCLES
) (
  input wire logic                   i_clk,
  input wire logic                   i_sys_rst,
  input wire logic [`SCM_ADDR_W-1:0] i_addr,
  input wire logic [7:0]             i_wdata,
  input wire logic                   i_wr,
  input wire logic                   i_rd,
  input wire logic                   i_halt,
  input wire logic                   i_wake,
  input wire logic                   i_crystal_sel,
  input wire logic                   i_wdt_en,
  input wire logic                   i_high_speed_clock,
  input wire logic                   i_low_speed_clock,
  input wire logic [7:0]             o_rdata,
  input wire logic                   o_cpu_run,
  input wire logic                   o_sys_tick,
  input wire logic                   o_hs_osc_en,
  input wire logic                   o_ls_osc_en,
  input wire scm_clk_sel_s           o_clk_sel,
  input wire scm_state_e             o_power_mode,
  input wire logic                   o_irq
);
  logic [7:0] mode_ff;  // shadow of the mode register
  logic [7:0] nxt_mode;
  logic [1:0] ctrl_ff;  // shadow of keep-clock and low-volt bits
  logic [1:0] nxt_ctrl;
  logic       slow;     // low clock routed to the system
  logic       fast;     // wake may borrow the low clock
  scm_state_e dest;     // where a halt must land
  // shadows follow bus writes so halt/wake targets can be predicted
  always_comb begin
    nxt_mode = mode_ff;
    nxt_ctrl = ctrl_ff;
    if (i_wr && i_addr == `SCM_ADDR_MODE) nxt_mode = i_wdata;
    if (i_wr && i_addr == `SCM_ADDR_CTRL) nxt_ctrl = i_wdata[1:0];
  end
  always_ff @(posedge i_clk) begin
    mode_ff <= i_sys_rst ? `SCM_MODE_RESET : nxt_mode;
    ctrl_ff <= i_sys_rst ? 2'h0 : nxt_ctrl;
  end
  assign slow = !mode_ff[0] && mode_ff[7:6] == 2'h0;
  assign fast = i_crystal_sel && mode_ff[4] && !slow;
  assign dest = mode_ff[1] ? (ctrl_ff[0] ? SCM_IDLE_RUN : SCM_IDLE_STOP)
                           : ((ctrl_ff[1] || i_wdt_en) ? SCM_SLEEP_SUB : SCM_SLEEP_OFF);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_halt;
    o_power_mode == SCM_RUN && i_halt;
  endsequence
  sequence s_wake(st);
    o_power_mode == st && i_wake;
  endsequence
  a_halt_dest: assert property (s_halt |=> o_power_mode == $past(dest))
    else $error("halt landed in wrong mode");
  a_halt_cpu_stop: assert property (s_halt |-> ##2 !o_cpu_run)
    else $error("cpu kept running after halt");
  a_idle_wake: assert property (s_wake(SCM_IDLE_RUN) |=> o_power_mode == SCM_RUN)
    else $error("idle wake did not return to run");
  a_deep_wake: assert property (s_wake(SCM_SLEEP_OFF) |=> o_power_mode == SCM_WAKE_WAIT)
    else $error("deep sleep wake used fast path");
  a_fast_choice: assert property ((o_power_mode inside {SCM_IDLE_STOP, SCM_SLEEP_SUB}) && i_wake
    |=> o_power_mode == ($past(fast) ? SCM_WAKE_LS : SCM_WAKE_WAIT))
    else $error("fast wake choice wrong");
  a_deep_osc_off: assert property (o_power_mode == SCM_SLEEP_OFF && $past(o_power_mode) == SCM_RUN
    |=> !o_hs_osc_en && !o_ls_osc_en)
    else $error("oscillators left on in deep sleep");
  a_slow_hs_off: assert property (o_power_mode == SCM_RUN && slow |-> ##[1:2] !o_hs_osc_en)
    else $error("high oscillator kept on with slow clock");
  a_wake_ls_clk: assert property (o_power_mode == SCM_WAKE_LS && o_cpu_run |-> o_clk_sel.use_low)
    else $error("fast wake not on low clock");
  a_full_sel: assert property (o_power_mode == SCM_RUN && $past(o_power_mode) == SCM_RUN
    && mode_ff[0] && $past(mode_ff[0]) |-> o_clk_sel.use_full && !o_clk_sel.use_low)
    else $error("undivided clock not routed");
  a_mode_read: assert property (i_rd && i_addr == `SCM_ADDR_MODE
    |=> {o_rdata[7:4], o_rdata[1:0]} == {$past(mode_ff[7:4]), $past(mode_ff[1:0])})
    else $error("mode readback wrong");
endmodule
bind scm_top scm_top_sva #(.HS_READY_CYCLES(HS_READY_CYCLES), .LS_READY_CYCLES(LS_READY_CYCLES)) i_sva (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .i_halt(i_halt), .i_wake(i_wake), .i_crystal_sel(i_crystal_sel), .i_wdt_en(i_wdt_en),
  .i_high_speed_clock(i_high_speed_clock), .i_low_speed_clock(i_low_speed_clock), .o_rdata(o_rdata),
  .o_cpu_run(o_cpu_run), .o_sys_tick(o_sys_tick), .o_hs_osc_en(o_hs_osc_en), .o_ls_osc_en(o_ls_osc_en),
  .o_clk_sel(o_clk_sel), .o_power_mode(o_power_mode), .o_irq(o_irq));

// ==== test/scm_top_tb.sv ====
// self-checking bench for the clock mode block
`timescale 1ns/1ps
`include "scm_params.svh"
module scm_top_tb;
  import scm_pkg::*;
  logic         i_clk = 0, i_sys_rst = 1, i_wr = 0, i_rd = 0, i_halt = 0, i_wake = 0;
  logic         i_crystal_sel = 1, i_wdt_en = 0, i_high_speed_clock = 0, i_low_speed_clock = 0;
  logic [7:0]   i_addr = 8'h00, i_wdata = 8'h00, o_rdata, rv;
  logic         o_cpu_run, o_sys_tick, o_hs_osc_en, o_ls_osc_en, o_irq, ls_ran;
  scm_clk_sel_s o_clk_sel;
  scm_state_e   o_power_mode;
  logic [4:0]   osc_cnt = 5'h00;  // slow oscillators, each level held at least 4 cycles
  int           err_count = 0, checks_done = 0;
  // short ready count keeps each wake under a hundred cycles
  scm_top #(.HS_READY_CYCLES(8), .LS_READY_CYCLES(2)) i_scm_top (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_halt(i_halt), .i_wake(i_wake),
    .i_crystal_sel(i_crystal_sel), .i_wdt_en(i_wdt_en), .i_high_speed_clock(i_high_speed_clock),
    .i_low_speed_clock(i_low_speed_clock), .o_rdata(o_rdata), .o_cpu_run(o_cpu_run), .o_sys_tick(o_sys_tick),
    .o_hs_osc_en(o_hs_osc_en), .o_ls_osc_en(o_ls_osc_en), .o_clk_sel(o_clk_sel),
    .o_power_mode(o_power_mode), .o_irq(o_irq));
  always #20 i_clk = ~i_clk;
  // oscillators only toggle while the block enables them
  always @(posedge i_clk) begin
    osc_cnt <= osc_cnt + 5'h01;
    i_high_speed_clock <= o_hs_osc_en & osc_cnt[2];
    i_low_speed_clock <= o_ls_osc_en & osc_cnt[4];
  end
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // read data is looked at in the one cycle it stands
  task automatic rd(logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  // system ticks seen over 64 cycles; the oscillator periods divide 64 exactly
  task automatic count_ticks(output logic [7:0] n);
    int k;
    n = 8'h00;
    for (k = 0; k < 64; k++) begin
      @(posedge i_clk);
      #1 n = n + {7'h00, o_sys_tick};
    end
  endtask
  task automatic pulse(bit w);  // one-cycle halt or wake, mode checked one cycle after
    @(posedge i_clk);
    if (w) i_wake <= 1'b1;
    else i_halt <= 1'b1;
    @(posedge i_clk);
    i_wake <= 1'b0;
    i_halt <= 1'b0;
    @(posedge i_clk);
    #1;
  endtask
  task automatic wait_run;
    int k;
    for (k = 0; k < 2000 && !(o_power_mode === SCM_RUN && o_cpu_run === 1'b1); k++) begin
      if (o_power_mode === SCM_WAKE_LS && o_cpu_run === 1'b1) ls_ran = 1;
      @(posedge i_clk);
      #1;
    end
    if (k == 2000) begin
      err_count++;
      $display("ERROR run wait expected 1 seen 0");
      close_out;
    end
  endtask
  task automatic t_reset_flags;
    rd(`SCM_ADDR_MODE, rv);
    chk("mode after power-on", 8'h07, rv & 8'hF7);
    wr(`SCM_ADDR_MODE, 8'h01);
    rd(`SCM_ADDR_MODE, rv);
    chk("ready flag kept", 8'h05, rv & 8'hF7);
    rd(8'h07, rv);
    chk("unmapped read", 8'h00, rv);
    rd(`SCM_ADDR_CLR, rv);
    chk("clear reg read", 8'h00, rv);
    $display("reset flags done");
  endtask
  task automatic t_clock;
    int k;
    for (k = 2; k < 8; k++) begin
      wr(`SCM_ADDR_MODE, {k[2:0], 5'h00});
      rd(`SCM_ADDR_MODE, rv);
      chk("divided routing", {5'h00, k[2:0]}, o_clk_sel);
    end
    count_ticks(rv);
    chk("half tick count", 8'h04, rv);
    wr(`SCM_ADDR_MODE, 8'h01);
    rd(`SCM_ADDR_MODE, rv);
    chk("full routing", 8'h08, o_clk_sel);
    count_ticks(rv);
    chk("full tick count", 8'h08, rv);
    wr(`SCM_ADDR_MODE, 8'h20);
    rd(`SCM_ADDR_MODE, rv);
    chk("slow routing", 8'h10, o_clk_sel & 8'h18);
    chk("high osc stopped", 8'h00, o_hs_osc_en);
    rd(`SCM_ADDR_MODE, rv);
    chk("high ready cleared", 8'h00, rv & 8'h04);
    count_ticks(rv);
    chk("slow tick count", 8'h02, rv);
    wr(`SCM_ADDR_MODE, 8'h01);
    for (k = 0; k < 100 && rv[2] !== 1'b1; k++) rd(`SCM_ADDR_MODE, rv);
    chk("high ready back", 8'h04, rv & 8'h04);
    $display("clock select done");
  endtask
  task automatic t_hw(logic [7:0] m, logic [7:0] c, logic w, logic x, scm_state_e s, logic [1:0] r,
                      scm_state_e ws);
    int k;
    rd(`SCM_ADDR_MODE, rv);
    // a slow oscillator restarted by the last wake needs a few of its own edges
    for (k = 0; k < 100 && rv[3] !== 1'b1; k++) rd(`SCM_ADDR_MODE, rv);
    chk("slow ready before halt", 8'h08, rv & 8'h08);
    wr(`SCM_ADDR_MODE, m);
    wr(`SCM_ADDR_CTRL, c);
    i_wdt_en <= w;
    i_crystal_sel <= x;
    pulse(0);
    chk("halt mode", s, o_power_mode);
    chk("cpu stopped", 8'h00, o_cpu_run);
    chk("slow osc enable", {7'h00, s != SCM_SLEEP_OFF}, {7'h00, o_ls_osc_en});
    // ready flags reach the register three cycles after the mode changes
    repeat (2) @(posedge i_clk);
    rd(`SCM_ADDR_MODE, rv);
    chk("ready flags asleep", {6'h00, r}, {6'h00, rv[3:2]});
    ls_ran = 0;
    pulse(1);
    chk("wake mode", ws, o_power_mode);
    wait_run;
    chk("ran on low clock", {7'h00, ws == SCM_WAKE_LS}, {7'h00, ls_ran});
    rd(`SCM_ADDR_MODE, rv);
    chk("high ready after wake", 8'h04, rv & 8'h04);
    $display("halt case done");
  endtask
  task automatic t_irq;
    wr(`SCM_ADDR_CLR, 8'h0F);
    wr(`SCM_ADDR_IEN, 8'h00);
    t_hw(8'h13, 8'h01, 0, 1, SCM_IDLE_RUN, 2'b11, SCM_RUN);
    chk("irq masked", 8'h00, o_irq);
    wr(`SCM_ADDR_IEN, 8'h04);
    rd(`SCM_ADDR_STAT, rv);
    chk("status wake done", 8'h04, rv);
    chk("irq raised", 8'h01, o_irq);
    wr(`SCM_ADDR_CLR, 8'h04);
    rd(`SCM_ADDR_STAT, rv);
    chk("status cleared", 8'h00, rv);
    chk("irq dropped", 8'h00, o_irq);
    $display("interrupt done");
  endtask
  initial begin
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd(`SCM_ADDR_MODE, rv);
    chk("high ready at power-on", 8'h00, rv & 8'h04);
    wait_run;
    t_reset_flags;
    t_clock;
    t_hw(8'h13, 8'h00, 0, 1, SCM_IDLE_STOP, 2'b10, SCM_WAKE_LS);
    t_hw(8'h11, 8'h02, 0, 0, SCM_SLEEP_SUB, 2'b10, SCM_WAKE_WAIT);
    t_hw(8'h11, 8'h00, 0, 1, SCM_SLEEP_OFF, 2'b00, SCM_WAKE_WAIT);
    t_hw(8'h11, 8'h00, 1, 1, SCM_SLEEP_SUB, 2'b10, SCM_WAKE_LS);
    t_irq;
    close_out;
  end
endmodule
